// >>> pkg/cpg_defs.vh
// Register map, field positions and reset values of the command pulse gear block
`ifndef CPG_DEFS_VH
`define CPG_DEFS_VH
`define CPG_ADDR_W 5
`define CPG_OFF_CTRL 5'h00
`define CPG_OFF_GEAR_NUM 5'h04
`define CPG_OFF_GEAR_DEN 5'h08
`define CPG_OFF_IN_FORM 5'h0C
`define CPG_OFF_DIR_SEL 5'h10
`define CPG_OFF_POS_CMD 5'h14
`define CPG_OFF_STATUS 5'h18
`define CPG_CTRL_POS_EN 0
`define CPG_GEAR_W 15
`define CPG_GEAR_MAX 15'h7FFF
`define CPG_GEAR_NUM_RST 15'h0010
`define CPG_GEAR_DEN_RST 15'h0001
`define CPG_FORM_PULSE_SIGN 2'h0
`define CPG_FORM_FWD_REV 2'h1
`define CPG_FORM_QUAD 2'h2
`define CPG_FORM_RST 2'h1
`define CPG_DIR_RST 2'h0
`define CPG_DIR_CW_BIT 0
`define CPG_DIR_ALEAD_BIT 1
`define CPG_ACTIVE_LSB 4
`define CPG_MAX_IN_KHZ 1000
`define CPG_CLK_KHZ 250000
`endif

// >>> src/cpg_command_pulse_gear.v
// Command pulse decoder, electronic gear and encoder emulation output
//
// Implementation choices: the address map and the Avalon-MM register port.
`include "cpg_defs.vh"
`default_nettype none

module cpg_command_pulse_gear #(
  parameter PEND_W = 8
) (
  input wire mclk,
  input wire reset_n,
  input wire [`CPG_ADDR_W-1:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  output reg [31:0] avsReadData,
  output reg avsWaitRequest,
  input wire cmdInFirst,
  input wire cmdInSecond,
  input wire fbStep,
  input wire fbForward,
  output reg encOutA,
  output reg encOutB,
  output reg [31:0] posCmd
);

  localparam S_IDLE = 3'b001;
  localparam S_DIV = 3'b010;
  localparam S_APPLY = 3'b100;

  // Stored settings survive reset like nonvolatile parameters; reset copies them to active
  reg [1:0] formStored_r = `CPG_FORM_RST;
  reg [1:0] dirStored_r = `CPG_DIR_RST;
  reg [1:0] formActive_r;
  reg [1:0] dirActive_r;
  reg posEn_r;
  reg [`CPG_GEAR_W-1:0] gearNum_r;
  reg [`CPG_GEAR_W-1:0] gearDen_r;

  reg signed [PEND_W-1:0] pend_r;
  reg [2:0] state_r;
  reg [4:0] divCnt_r;
  reg [16:0] rmd_r;
  reg [16:0] quo_r;
  reg [`CPG_GEAR_W-1:0] divisor_r;
  reg resNeg_r;
  reg signed [15:0] rem_r;
  reg [1:0] encCnt_r;

  wire busReq = avsRead | avsWrite;
  wire wrHit = avsWrite & ~avsWaitRequest;
  wire gearOk = (avsWriteData[31:15] == 17'h00000) && (avsWriteData[14:0] != 15'h0000);

  function [31:0] regRead;
    input [`CPG_ADDR_W-1:0] addr;
    begin
      case (addr)
        `CPG_OFF_CTRL: regRead = {31'h00000000, posEn_r};
        `CPG_OFF_GEAR_NUM: regRead = {17'h00000, gearNum_r};
        `CPG_OFF_GEAR_DEN: regRead = {17'h00000, gearDen_r};
        `CPG_OFF_IN_FORM: regRead = {26'h0000000, formActive_r, 2'h0, formStored_r};
        `CPG_OFF_DIR_SEL: regRead = {26'h0000000, dirActive_r, 2'h0, dirStored_r};
        `CPG_OFF_POS_CMD: regRead = posCmd;
        `CPG_OFF_STATUS: regRead = {rem_r, 7'h00, (state_r != S_IDLE), pend_r};
        default: regRead = 32'h00000000;
      endcase
    end
  endfunction

  reg waitReq_nxt;
  always @* begin
    // Exactly one wait state per request, then a forced idle cycle
    waitReq_nxt = 1'b1;
    if (busReq && avsWaitRequest) begin
      waitReq_nxt = 1'b0;
    end
  end

  // Avalon slave: one wait cycle, data registered while waitrequest is high
  always @(posedge mclk) begin
    if (!reset_n) begin
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h00000000;
    end else begin
      avsWaitRequest <= waitReq_nxt;
      if (avsRead && avsWaitRequest) begin
        avsReadData <= regRead(avsAddress);
      end
    end
  end

  always @(posedge mclk) begin
    if (wrHit && avsAddress == `CPG_OFF_IN_FORM && avsWriteData[1:0] != 2'h3) begin
      formStored_r <= avsWriteData[1:0];
    end
    if (wrHit && avsAddress == `CPG_OFF_DIR_SEL) begin
      dirStored_r <= avsWriteData[1:0];
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      formActive_r <= formStored_r;
      dirActive_r <= dirStored_r;
      posEn_r <= 1'b0;
      gearNum_r <= `CPG_GEAR_NUM_RST;
      gearDen_r <= `CPG_GEAR_DEN_RST;
    end else if (wrHit) begin
      if (avsAddress == `CPG_OFF_CTRL) begin
        posEn_r <= avsWriteData[`CPG_CTRL_POS_EN];
      end
      // Out of range values are dropped so a zero divisor never reaches the gear
      if (avsAddress == `CPG_OFF_GEAR_NUM && gearOk) begin
        gearNum_r <= avsWriteData[14:0];
      end
      if (avsAddress == `CPG_OFF_GEAR_DEN && gearOk) begin
        gearDen_r <= avsWriteData[14:0];
      end
    end
  end

  // Two stage synchronisers; edge detection only looks at the second stage
  wire [1:0] pinIn = {cmdInSecond, cmdInFirst};
  wire [1:0] pinSync;
  wire [1:0] pinPrev;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      reg meta_r;
      reg sync_r;
      reg prev_r;
      always @(posedge mclk) begin
        if (!reset_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
        end else begin
          meta_r <= pinIn[gi];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end
      assign pinSync[gi] = sync_r;
      assign pinPrev[gi] = prev_r;
    end
  endgenerate

  // Channel 0 carries pulses, channel 1 sign or reverse pulses
  wire firstSync = pinSync[0];
  wire secondSync = pinSync[1];
  wire firstRise = firstSync & ~pinPrev[0];
  wire secondRise = secondSync & ~pinPrev[1];
  wire firstChg = firstSync ^ pinPrev[0];
  wire secondChg = secondSync ^ pinPrev[1];

  reg cmdUp;
  reg cmdDown;
  always @* begin
    cmdUp = 1'b0;
    cmdDown = 1'b0;
    case (formActive_r)
      `CPG_FORM_PULSE_SIGN: begin
        cmdUp = firstRise & secondSync;
        cmdDown = firstRise & ~secondSync;
      end
      `CPG_FORM_FWD_REV: begin
        cmdUp = firstRise & ~secondRise;
        cmdDown = secondRise & ~firstRise;
      end
      `CPG_FORM_QUAD: begin
        // Both phases moving at once is an illegal jump and is not counted
        if (firstChg && !secondChg) begin
          cmdUp = (firstSync == secondSync);
          cmdDown = (firstSync != secondSync);
        end else if (secondChg && !firstChg) begin
          cmdUp = (firstSync != secondSync);
          cmdDown = (firstSync == secondSync);
        end
      end
      default: begin
        cmdUp = 1'b0;
        cmdDown = 1'b0;
      end
    endcase
  end

  // CW-positive settings invert the command so positive motion turns the shaft clockwise
  wire dirCw = dirActive_r[`CPG_DIR_CW_BIT];
  wire unitUp = posEn_r & (dirCw ? cmdDown : cmdUp);
  wire unitDown = posEn_r & (dirCw ? cmdUp : cmdDown);
  wire startDiv = (state_r == S_IDLE) && (pend_r != {PEND_W{1'b0}});
  wire takeNeg = pend_r[PEND_W-1];

  // Pending edges queue up while a division runs; 19 cycles each, far below 1 MHz spacing
  reg signed [PEND_W-1:0] pend_nxt;
  always @* begin
    pend_nxt = pend_r;
    if (unitUp) begin
      pend_nxt = pend_nxt + 1'b1;
    end
    if (unitDown) begin
      pend_nxt = pend_nxt - 1'b1;
    end
    if (startDiv && !takeNeg) begin
      pend_nxt = pend_nxt - 1'b1;
    end
    if (startDiv && takeNeg) begin
      pend_nxt = pend_nxt + 1'b1;
    end
  end

  wire signed [16:0] remExt = {rem_r[15], rem_r};
  wire signed [16:0] numExt = {2'b00, gearNum_r};
  wire signed [16:0] gearSum = takeNeg ? (remExt - numExt) : (remExt + numExt);
  wire [16:0] gearMag = gearSum[16] ? (17'h00000 - gearSum) : gearSum;
  wire [16:0] divShift = {rmd_r[15:0], quo_r[16]};
  wire divFit = divShift >= {2'b00, divisor_r};
  wire [16:0] divSub = divShift - {2'b00, divisor_r};
  wire [31:0] quoExt = {15'h0000, quo_r};
  wire [15:0] remMag = rmd_r[15:0];

  reg [2:0] state_nxt;
  reg [4:0] divCnt_nxt;
  reg [16:0] rmd_nxt;
  reg [16:0] quo_nxt;
  reg [`CPG_GEAR_W-1:0] divisor_nxt;
  reg resNeg_nxt;
  reg signed [15:0] rem_nxt;
  reg [31:0] posCmd_nxt;

  // Restoring divider, one quotient bit per cycle keeps the gear to one subtractor
  always @* begin
    state_nxt = state_r;
    divCnt_nxt = divCnt_r;
    rmd_nxt = rmd_r;
    quo_nxt = quo_r;
    divisor_nxt = divisor_r;
    resNeg_nxt = resNeg_r;
    rem_nxt = rem_r;
    posCmd_nxt = posCmd;
    case (state_r)
      S_IDLE: begin
        if (startDiv) begin
          // Remainder plus signed numerator, divided by denominator
          rmd_nxt = 17'h00000;
          quo_nxt = gearMag;
          resNeg_nxt = gearSum[16];
          divisor_nxt = gearDen_r;
          divCnt_nxt = 5'h11;
          state_nxt = S_DIV;
        end
      end
      S_DIV: begin
        rmd_nxt = divFit ? divSub : divShift;
        quo_nxt = {quo_r[15:0], divFit};
        divCnt_nxt = divCnt_r - 5'h01;
        if (divCnt_r == 5'h01) begin
          state_nxt = S_APPLY;
        end
      end
      S_APPLY: begin
        posCmd_nxt = resNeg_r ? (posCmd - quoExt) : (posCmd + quoExt);
        rem_nxt = resNeg_r ? (16'h0000 - remMag) : remMag;
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      pend_r <= {PEND_W{1'b0}};
      state_r <= S_IDLE;
      divCnt_r <= 5'h00;
      rmd_r <= 17'h00000;
      quo_r <= 17'h00000;
      divisor_r <= `CPG_GEAR_DEN_RST;
      resNeg_r <= 1'b0;
      rem_r <= 16'h0000;
      posCmd <= 32'h00000000;
    end else begin
      pend_r <= pend_nxt;
      state_r <= state_nxt;
      divCnt_r <= divCnt_nxt;
      rmd_r <= rmd_nxt;
      quo_r <= quo_nxt;
      divisor_r <= divisor_nxt;
      resNeg_r <= resNeg_nxt;
      rem_r <= rem_nxt;
      posCmd <= posCmd_nxt;
    end
  end

  // Encoder emulation follows shaft steps only, never the gear
  reg [1:0] encCnt_nxt;
  always @* begin
    encCnt_nxt = encCnt_r;
    if (fbStep) begin
      encCnt_nxt = fbForward ? encCnt_r + 2'h1 : encCnt_r - 2'h1;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      encCnt_r <= 2'h0;
      encOutA <= 1'b0;
      encOutB <= 1'b0;
    end else begin
      encCnt_r <= encCnt_nxt;
      // Gray sequence 00,01,11,10 on A,B makes B lead when counting up; with the A-lead bit set it is 00,10,11,01 and A leads
      if (dirActive_r[`CPG_DIR_ALEAD_BIT]) begin
        encOutA <= encCnt_r[1] ^ encCnt_r[0];
        encOutB <= encCnt_r[1];
      end else begin
        encOutA <= encCnt_r[1];
        encOutB <= encCnt_r[1] ^ encCnt_r[0];
      end
    end
  end

endmodule

`default_nettype wire

// >>> testbench/cpg_props.sv
// Port checker for the command pulse gear block
`default_nettype none
module cpg_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  input wire logic cmdInFirst,
  input wire logic cmdInSecond,
  input wire logic fbStep,
  input wire logic encOutA,
  input wire logic encOutB,
  input wire logic [31:0] posCmd
);
  logic [7:0] quietCnt_r;
  logic [1:0] pinPrev_r;
  // Pins quiet this long means every pending unit has long been applied
  always_ff @(posedge mclk) begin
    pinPrev_r <= {cmdInFirst, cmdInSecond};
    if (!reset_n || pinPrev_r != {cmdInFirst, cmdInSecond}) quietCnt_r <= 8'h00;
    else if (quietCnt_r != 8'hFF) quietCnt_r <= quietCnt_r + 8'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wait_one_a: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("bus answer late");
  wait_short_a: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("bus answer too long");
  wait_idle_a: assert property (!(avsRead || avsWrite) |=> avsWaitRequest)
    else $error("bus answer without request");
  unmapped_zero_a: assert property (avsRead && avsWaitRequest && avsAddress == 5'h1C
    |=> avsReadData == 32'h0) else $error("unmapped read not zero");
  read_hold_a: assert property (!$past(avsRead) |-> $stable(avsReadData))
    else $error("read data moved");
  pos_quiet_a: assert property (quietCnt_r == 8'hFF |-> $stable(posCmd))
    else $error("position moved without pulses");
  enc_lag_a: assert property (fbStep && !$past(fbStep) && !$past(fbStep, 2)
    |-> ##2 ({encOutA, encOutB} != $past({encOutA, encOutB}, 2))) else $error("encoder late");
  enc_gray_a: assert property (!($changed(encOutA) && $changed(encOutB)))
    else $error("both phases moved");
  enc_still_a: assert property (!$past(fbStep) && !$past(fbStep, 2)
    |-> $stable({encOutA, encOutB})) else $error("encoder moved without step");
  cover property (fbStep ##2 $changed({encOutA, encOutB}));
  cover property ($changed(posCmd));
  cover property (avsWrite && !avsWaitRequest);
endmodule
bind cpg_command_pulse_gear cpg_props cpg_props_i (.mclk, .reset_n, .avsAddress, .avsRead,
  .avsWrite, .avsReadData, .avsWaitRequest, .cmdInFirst, .cmdInSecond, .fbStep, .encOutA,
  .encOutB, .posCmd);
`default_nettype wire

// >>> testbench/cpg_host_model.sv
// Host controller model that drives command pulse trains
`default_nettype none
module cpg_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] form,
  input wire logic up,
  input wire logic [7:0] n,
  output logic first,
  output logic second,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int i;
  initial begin
    first = 1'b0;
    second = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        if (form == 2'h0) second <= up;
        for (i = 0; i < n; i++) begin
          // 125 cycles per level keeps the rate at 1 MHz
          repeat (125) @(posedge clk);
          if (form == 2'h2) begin
            if ((first == second) == up) second <= ~second;
            else first <= ~first;
          end else begin
            if (form == 2'h0 || up) first <= 1'b1;
            else second <= 1'b1;
            repeat (125) @(posedge clk);
            first <= 1'b0;
            if (form != 2'h0) second <= 1'b0;
          end
        end
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/command_pulse_input_gear_bench.sv
// Self-checking bench for the command pulse gear block
`include "cpg_defs.vh"
`default_nettype none
module command_pulse_input_gear_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, reset_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
  logic fbStep = 1'b0, fbForward = 1'b0, go = 1'b0, up = 1'b0, busy;
  logic cmdInFirst, cmdInSecond, encOutA, encOutB, avsWaitRequest;
  logic [4:0] avsAddress = 5'h00;
  logic [31:0] avsWriteData = 32'h0, avsReadData, posCmd, q;
  logic [1:0] form = 2'h1;
  logic [7:0] n = 8'h00;
  int miscompares = 0, n_tests = 0;
  always #2 mclk = ~mclk;
  cpg_command_pulse_gear cpg_command_pulse_gear_i (.mclk, .reset_n, .avsAddress, .avsRead,
    .avsWrite, .avsWriteData, .avsReadData, .avsWaitRequest, .cmdInFirst, .cmdInSecond,
    .fbStep, .fbForward, .encOutA, .encOutB, .posCmd);
  cpg_host_model cpg_host_model_i (.clk(mclk), .go, .form, .up, .n, .first(cmdInFirst),
    .second(cmdInSecond), .busy);
  task automatic give_verdict;
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= ~w;
    do @(posedge mclk); while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, q);
  endtask
  task automatic send(input logic [1:0] f, input logic u, input logic [7:0] k);
    form <= f;
    up <= u;
    n <= k;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    while (busy === 1'b1) @(posedge mclk);
    repeat (40) @(posedge mclk);
  endtask
  task automatic step(input logic fw, input logic [1:0] e);
    fbStep <= 1'b1;
    fbForward <= fw;
    @(posedge mclk);
    fbStep <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("encoder", {30'h0, e}, {30'h0, encOutA, encOutB});
  endtask
  // Reset doubles as the power cycle that activates stored form and direction
  task automatic boot;
    reset_n <= 1'b0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
  initial begin
    boot();
    rc(`CPG_OFF_CTRL, 32'h0);
    rc(`CPG_OFF_GEAR_NUM, 32'h10);
    rc(`CPG_OFF_GEAR_DEN, 32'h1);
    rc(`CPG_OFF_IN_FORM, 32'h11);
    rc(`CPG_OFF_DIR_SEL, 32'h0);
    rc(5'h1C, 32'h0);
    send(2'h1, 1'b1, 8'h03);
    rc(`CPG_OFF_POS_CMD, 32'h0);
    bus(1'b1, `CPG_OFF_CTRL, 32'h1);
    send(2'h1, 1'b1, 8'h02);
    send(2'h1, 1'b0, 8'h01);
    chk("posCmd", 32'h10, posCmd);
    bus(1'b1, `CPG_OFF_GEAR_NUM, 32'h0);
    bus(1'b1, `CPG_OFF_GEAR_NUM, 32'h8003);
    rc(`CPG_OFF_GEAR_NUM, 32'h10);
    bus(1'b1, `CPG_OFF_GEAR_NUM, 32'h3);
    bus(1'b1, `CPG_OFF_GEAR_DEN, 32'h2);
    send(2'h1, 1'b1, 8'h03);
    chk("posCmd", 32'h14, posCmd);
    send(2'h1, 1'b1, 8'h01);
    chk("posCmd", 32'h16, posCmd);
    bus(1'b1, `CPG_OFF_IN_FORM, 32'h2);
    bus(1'b1, `CPG_OFF_DIR_SEL, 32'h3);
    rc(`CPG_OFF_IN_FORM, 32'h12);
    boot();
    rc(`CPG_OFF_IN_FORM, 32'h22);
    rc(`CPG_OFF_DIR_SEL, 32'h33);
    bus(1'b1, `CPG_OFF_CTRL, 32'h1);
    send(2'h2, 1'b1, 8'h04);
    chk("posCmd", 32'hFFFFFFC0, posCmd);
    send(2'h2, 1'b0, 8'h02);
    chk("posCmd", 32'hFFFFFFE0, posCmd);
    send(2'h2, 1'b1, 8'h02);
    step(1'b1, 2'h2);
    bus(1'b1, `CPG_OFF_IN_FORM, 32'h0);
    bus(1'b1, `CPG_OFF_DIR_SEL, 32'h0);
    bus(1'b1, `CPG_OFF_IN_FORM, 32'h3);
    boot();
    rc(`CPG_OFF_IN_FORM, 32'h0);
    bus(1'b1, `CPG_OFF_CTRL, 32'h1);
    send(2'h0, 1'b1, 8'h02);
    send(2'h0, 1'b0, 8'h03);
    chk("posCmd", 32'hFFFFFFF0, posCmd);
    step(1'b1, 2'h1);
    step(1'b0, 2'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
